// ### testbench/ctrl_model.sv
// External display controller model: serial chain and blank pin.
// Assumes clk_sys at 50 MHz; link clock period is 8 clk (160 ns).
`timescale 1ns/1ps
module ctrl_model
(
  // Clock
  input wire logic clk_sys,
  // Link pins
  output logic shift_clock,
  output logic serial_in,
  output logic latch_strobe,
  output logic output_blank,
  // Observed device pins
  input wire logic serial_out,
  input wire logic probe_sink,
  input wire logic leak_source
);
  // ------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------
  // Link clock stands still low outside frames; blank starts high
  initial
  begin
    shift_clock = 1'b0;
    serial_in = 1'b0;
    latch_strobe = 1'b0;
    output_blank = 1'b1;
  end
  logic last_out; // Serial out seen at the last shift clock rise
  // Wait n system clocks
  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // One link clock period, data set in the low phase
  task automatic pulse(input logic b);
    serial_in <= b;
    hold(4);
    last_out = serial_out;
    shift_clock <= 1'b1;
    hold(4);
    shift_clock <= 1'b0;
  endtask
  // Latch pulse, then time for the latches to settle
  task automatic strobe();
    latch_strobe <= 1'b1;
    hold(4);
    latch_strobe <= 1'b0;
    hold(8);
  endtask
  // Shift 17 bits MSB first, collect the outgoing bits, latch
  task automatic send(input logic [16:0] w, output logic [16:0] r);
    for (int i = 16; i >= 0; i--)
    begin
      pulse(w[i]);
      r[i] = last_out;
    end
    // Idle data line must not keep showing the last bit
    serial_in <= ~w[0];
    hold(4);
    strobe();
  endtask
  // Blank low well past the 25 clk settle time
  task automatic blank(input int n, output int pc, output logic ls);
    pc = 0;
    output_blank <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      @(negedge clk_sys);
      if (probe_sink === 1'b1)
        pc++;
      if (i == n / 2)
        ls = leak_source;
    end
    @(posedge clk_sys);
    output_blank <= 1'b1;
    hold(8);
  endtask
  // Return from sleep takes 20 us before enable or read
  task automatic settle();
    hold(1000);
  endtask
endmodule

// ### testbench/led_diag_tb.sv
// Self-checking bench for the LED diagnostic block.
// Assumes the controller model drives the link pins.
`timescale 1ns/1ps
`include "led_diag_defs.svh"
`define CHK(a, b) \
  begin \
    samples_checked++; \
    if ((a) !== (b)) \
    begin \
      n_fail++; \
      $display("BAD t=%0t got %h exp %h", $time, a, b); \
    end \
  end
module led_diag_tb;
  logic clk_sys, rst_b, shift_clock, serial_in, latch_strobe;
  logic output_blank, serial_out, probe_sink, leak_source, sleep_mode;
  logic [15:0] open_cmp, short_cmp, leak_cmp, out_drive;
  logic overtemp_shutdown_flag, overtemp_warning, ref_short_flag;
  logic [1:0] probe_current_select, short_threshold_select;
  logic [6:0] brightness;
  logic cyc_i, stb_i, we_i, ack_o;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, q;
  logic [16:0] r;
  int n_fail = 0;
  int samples_checked = 0;

  led_diag dut_u (.clk_sys(clk_sys), .rst_b(rst_b),
    .shift_clock(shift_clock), .serial_in(serial_in),
    .latch_strobe(latch_strobe), .output_blank(output_blank),
    .serial_out(serial_out), .open_cmp(open_cmp), .short_cmp(short_cmp),
    .leak_cmp(leak_cmp), .overtemp_shutdown_flag(overtemp_shutdown_flag),
    .overtemp_warning(overtemp_warning), .ref_short_flag(ref_short_flag),
    .out_drive(out_drive), .probe_sink(probe_sink),
    .leak_source(leak_source), .probe_current_select(probe_current_select),
    .short_threshold_select(short_threshold_select),
    .brightness(brightness), .sleep_mode(sleep_mode), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o));
  ctrl_model ctl_u (.clk_sys(clk_sys), .shift_clock(shift_clock),
    .serial_in(serial_in), .latch_strobe(latch_strobe),
    .output_blank(output_blank), .serial_out(serial_out),
    .probe_sink(probe_sink), .leak_source(leak_source));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Control frame: MSB set, threshold 3, full brightness
  function automatic logic [16:0] ctrl(logic se, logic [1:0] tm,
    logic [1:0] cu, logic [1:0] sl);
    return {1'b1, se, tm, cu, 2'h3, sl, 7'h7f};
  endfunction
  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Classic Wishbone cycle, waits for ack under a bound
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] rd);
    int k;
    @(posedge clk_sys);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      k++;
    end while (ack_o !== 1'b1 && k < 50);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (k >= 50)
    begin
      n_fail++;
      finish_test();
    end
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Reset values, unmapped read, refused divider write
  task automatic t_reset();
    wb(0, `ADR_LATCH, 0, q);
    `CHK(q, 32'he67f0000)
    wb(0, `ADR_STATUS, 0, q);
    `CHK(q[15:0], 16'h0000)
    wb(0, 8'h0c, 0, q);
    `CHK(q, 32'h00000000)
    wb(1, `ADR_OSC_DIV, 0, q);
    wb(0, `ADR_OSC_DIV, 0, q);
    `CHK(q[7:0], `OSC_DIV_RESET)
    `CHK(probe_current_select, 2'h0)
    `CHK({brightness, short_threshold_select, out_drive}, 25'h1ff0000)
  endtask
  // Each detector group, masking, flag override, stale latch
  task automatic t_sel();
    logic [15:0] e;
    int pc;
    logic ls;
    for (int s = 1; s < 4; s++)
    begin
      ctl_u.send(ctrl(0, 0, 0, s[1:0]), r);
      ctl_u.send({1'b0, 16'h0f0f}, r);
      `CHK(r, ctrl(0, 0, 0, s[1:0]))
      ctl_u.blank(40, pc, ls);
      `CHK(pc, 0)
      `CHK(ls, s == 3)
      ctl_u.send({1'b0, 16'h0f0f}, r);
      ctl_u.send({1'b0, 16'h0f0f}, r);
      e = s == 1 ? 16'h0c0c : s == 2 ? 16'h0a0a : 16'h9090;
      `CHK(r[15:0], e)
      {overtemp_shutdown_flag, overtemp_warning, ref_short_flag} <=
        3'h4 >> (s - 1);
      ctl_u.send({1'b0, 16'h0f0f}, r);
      ctl_u.send({1'b0, 16'h0f0f}, r);
      `CHK(r[15:0], 16'hffff)
      {overtemp_shutdown_flag, overtemp_warning, ref_short_flag} <= 3'h0;
      ctl_u.strobe();
      ctl_u.send({1'b0, 16'h0f0f}, r);
      `CHK(r[15:0], 16'hffff)
    end
    ctl_u.send(ctrl(0, 0, 0, 0), r);
    ctl_u.send({1'b0, 16'h1234}, r);
    ctl_u.send({1'b0, 16'h0f0f}, r);
    `CHK(r, {1'b0, 16'h1234})
  endtask
  // Probe window length per code, early stop, unmasked capture
  task automatic t_probe();
    int pc;
    int ex;
    logic ls;
    for (int k = 0; k < 4; k++)
    begin
      ctl_u.send(ctrl(0, k[1:0], 2'h1, k == 2 ? 2'h3 : 2'h1), r);
      ex = 2 * ((16 << k) + 1);
      ctl_u.blank(300, pc, ls);
      `CHK(pc >= ex - 3 && pc <= ex + 3, 1'b1)
      `CHK(ls, 1'b0)
    end
    ctl_u.blank(100, pc, ls);
    `CHK(pc >= 90 && pc <= 100, 1'b1)
    ctl_u.send({1'b0, 16'h0f0f}, r);
    ctl_u.send({1'b0, 16'h0f0f}, r);
    `CHK(r[15:0], 16'h3c3c)
  endtask
  // Sleep entry both ways, wake by shift clock, disabled sleep
  task automatic t_sleep();
    ctl_u.send(ctrl(1, 0, 0, 0), r);
    `CHK(sleep_mode, 1'b0)
    ctl_u.send({1'b0, 16'h0000}, r);
    `CHK(sleep_mode, 1'b1)
    wb(0, `ADR_STATUS, 0, q);
    `CHK(q[16], 1'b1)
    ctl_u.pulse(1'b0);
    `CHK(sleep_mode, 1'b0)
    ctl_u.settle();
    ctl_u.send(ctrl(1, 0, 0, 0), r);
    `CHK(sleep_mode, 1'b1)
    ctl_u.pulse(1'b0);
    ctl_u.settle();
    ctl_u.send(ctrl(0, 0, 0, 0), r);
    ctl_u.send({1'b0, 16'h0000}, r);
    `CHK(sleep_mode, 1'b0)
  endtask

  // ------------------------------------------------------------
  // Clock, reset and main sequence
  // ------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial
  begin
    rst_b = 1'b0;
    {cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
    sel_i = 4'hf;
    open_cmp = 16'h3c3c;
    short_cmp = 16'h5a5a;
    leak_cmp = 16'h9696;
    {overtemp_shutdown_flag, overtemp_warning, ref_short_flag} = 3'h0;
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_reset();
    t_sel();
    t_probe();
    t_sleep();
    finish_test();
  end
endmodule

// ### verilog/led_diag.sv
// Diagnostic, status capture and sleep logic of a 16-channel LED driver.
// Assumes pins and comparator levels arrive asynchronous to clk_sys,
// and a classic Wishbone master on the same clock.
`timescale 1ns/1ps
`include "led_diag_defs.svh"

// Function
// - Select 00 loads nothing on latch
// - Select 01 loads open, all ones shutdown
// - Select 10 loads short, all ones warning
// - Select 11 loads leak, all ones ref short
// - Sleep on all-zero write when enabled
// - Shift clock edge wakes from sleep
// - Sleep disabled never enters sleep
// - Open bit masked for off outputs with probe current 00
// - Open results captured blank or probe end
// - Results invalid 0.5 us after turn-on
// - Short results captured blank or probe end
// - Short bit masked for off outputs with probe current 00
// - Probe sinks from blank fall until stop or window expiry
// - Probe stop latches selected detector
// - Probe current 00 disables probe
// - Probe mode disables leakage detection
// - Leak source only select 11, blank low
// - Leak bit for off outputs, blank rise
// - MSB 0 copies data then loads status
// - Latch ignored without fresh shifted data
// - Probe time 17/33/65/129 oscillator cycles
// - Status select at control bits 8:7
// - Probe current at control bits 12:11
// - Sleep enable at bit 15, default 1
module led_diag
#(
  parameter logic [7:0] OSC_DIV_INIT = `OSC_DIV_RESET
)
(
  // System
  input wire logic clk_sys,
  input wire logic rst_b,
  // Serial link pins
  input wire logic shift_clock,
  input wire logic serial_in,
  input wire logic latch_strobe,
  input wire logic output_blank,
  output logic serial_out,
  // Comparator and flag levels
  input wire logic [15:0] open_cmp,
  input wire logic [15:0] short_cmp,
  input wire logic [15:0] leak_cmp,
  input wire logic overtemp_shutdown_flag,
  input wire logic overtemp_warning,
  input wire logic ref_short_flag,
  // Output stage controls
  output logic [15:0] out_drive,
  output logic probe_sink,
  output logic leak_source,
  output logic [1:0] probe_current_select,
  output logic [1:0] short_threshold_select,
  output logic [6:0] brightness,
  output logic sleep_mode,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o
);

  // ----------------------------------------------------------------
  // Derived timing
  // ----------------------------------------------------------------
  localparam int SETTLE_CYC = (`SETTLE_NS * `CLK_MHZ + 999) / 1000;
  localparam int WAKE_CYC = `WAKE_US * `CLK_MHZ;
  localparam int SYNC_W = 55;

  initial
  begin
    if (OSC_DIV_INIT == 8'h00)
      $error("led_diag: OSC_DIV_INIT must be nonzero");
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] meta_reg; // First stage, read only by stage two
  logic [SYNC_W-1:0] sync_reg; // Second stage, safe to use
  logic [2:0] pin_d_reg; // Delayed blank, latch and shift clock

  // Two flops for every asynchronous level
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // Blank idles high, so its stages reset high: no false edge
      meta_reg <= SYNC_W'(4'h8);
      sync_reg <= SYNC_W'(4'h8);
    end
    else
    begin
      meta_reg <= {overtemp_shutdown_flag, overtemp_warning, ref_short_flag,
                   leak_cmp, short_cmp, open_cmp, output_blank,
                   latch_strobe, serial_in, shift_clock};
      sync_reg <= meta_reg;
    end
  end

  logic sclk_s, sin_s, lat_s, blank_s; // Clean pin levels
  logic [15:0] open_s, short_s, leak_s; // Clean comparator levels
  logic tsd_s, ptw_s, isf_s; // Clean flags

  assign {tsd_s, ptw_s, isf_s, leak_s, short_s, open_s, blank_s, lat_s,
          sin_s, sclk_s} = sync_reg;

  // Previous levels; blank resets high so no false blank edge at start
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      pin_d_reg <= 3'h4;
    else
      pin_d_reg <= {blank_s, lat_s, sclk_s};
  end

  logic sclk_rise, lat_rise, blank_rise, blank_fall; // One-cycle edges

  assign sclk_rise = sclk_s && !pin_d_reg[0];
  assign lat_rise = lat_s && !pin_d_reg[1];
  assign blank_rise = blank_s && !pin_d_reg[2];
  assign blank_fall = !blank_s && pin_d_reg[2];

  // ----------------------------------------------------------------
  // Shift register, latches and power state
  // ----------------------------------------------------------------
  logic [16:0] shift_reg; // Common shift register
  logic [15:0] onoff_reg; // Output on/off latch
  logic [15:0] ctrl_reg; // Function control latch
  logic [15:0] holder_reg; // Status holder
  logic fresh_reg; // New bits shifted since last latch
  led_diag_pkg::power_state_type pwr_reg; // Power state
  logic [9:0] wake_cnt_reg; // Wake-up delay counter
  led_diag_pkg::status_sel_type sel; // Decoded status select
  logic probe_en; // Hidden probe mode on
  logic latch_go; // Accepted latch strobe
  logic onoff_wr; // Latch targets on/off data
  logic go_sleep; // Sleep entry condition
  logic running; // Detection alive
  logic [15:0] status_word; // Word loaded into shift register

  assign sel = led_diag_pkg::status_sel_type'(
                 ctrl_reg[`CTRL_SEL_HI:`CTRL_SEL_LO]);
  assign probe_en = |ctrl_reg[`CTRL_CUR_HI:`CTRL_CUR_LO];
  assign latch_go = lat_rise && fresh_reg;
  assign onoff_wr = !shift_reg[`SR_MSB];
  assign running = (pwr_reg == led_diag_pkg::PWR_RUN);

  // Enable bit is the stored one for data writes, the new one otherwise
  assign go_sleep = latch_go && (onoff_wr ?
    (ctrl_reg[`CTRL_SLEEP_BIT] && shift_reg[15:0] == 16'h0000) :
    (shift_reg[`CTRL_SLEEP_BIT] && onoff_reg == 16'h0000));

  // Status word with the flag override per group
  always_comb
  begin
    unique case (sel)
      led_diag_pkg::SEL_OPEN:
        status_word = tsd_s ? 16'hffff : holder_reg;
      led_diag_pkg::SEL_SHORT:
        status_word = ptw_s ? 16'hffff : holder_reg;
      led_diag_pkg::SEL_LEAK:
        status_word = isf_s ? 16'hffff : holder_reg;
      led_diag_pkg::SEL_NONE:
        status_word = shift_reg[15:0];
    endcase
  end

  // Shift in on clock edges, load status on accepted data latches
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      shift_reg <= '0;
    else if (latch_go && onoff_wr)
      shift_reg[15:0] <= status_word;
    else if (sclk_rise)
      shift_reg <= {shift_reg[15:0], sin_s};
  end

  // Copy happens from the old contents, before the status load
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      onoff_reg <= '0;
      ctrl_reg <= `CTRL_RESET;
    end
    else if (latch_go && onoff_wr)
      onoff_reg <= shift_reg[15:0];
    else if (latch_go)
      ctrl_reg <= shift_reg[15:0];
  end

  // Fresh data flag; a shift edge beside an accept keeps it set
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      fresh_reg <= 1'b0;
    else if (sclk_rise)
      fresh_reg <= 1'b1;
    else if (latch_go)
      fresh_reg <= 1'b0;
  end

  // Power state; wake delay models the analog return time
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pwr_reg <= led_diag_pkg::PWR_RUN;
      wake_cnt_reg <= '0;
    end
    else
    begin
      unique case (pwr_reg)
        led_diag_pkg::PWR_RUN:
          if (go_sleep)
            pwr_reg <= led_diag_pkg::PWR_SLEEP;
        led_diag_pkg::PWR_SLEEP:
          if (sclk_rise)
          begin
            pwr_reg <= led_diag_pkg::PWR_WAKE;
            wake_cnt_reg <= '0;
          end
        led_diag_pkg::PWR_WAKE:
          if (go_sleep)
            pwr_reg <= led_diag_pkg::PWR_SLEEP;
          else if (wake_cnt_reg == 10'(WAKE_CYC - 1))
            pwr_reg <= led_diag_pkg::PWR_RUN;
          else
            wake_cnt_reg <= wake_cnt_reg + 1'b1;
        default:
          pwr_reg <= led_diag_pkg::PWR_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Oscillator divider and probe window
  // ----------------------------------------------------------------
  logic [7:0] osc_div_reg; // Software divide count
  logic [7:0] osc_cnt_reg; // Divider phase
  logic osc_tick; // Oscillator enable pulse
  probe_if pif();

  // Enable pulse every osc_div_reg+1 cycles
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      osc_cnt_reg <= '0;
    else if (osc_cnt_reg >= osc_div_reg)
      osc_cnt_reg <= '0;
    else
      osc_cnt_reg <= osc_cnt_reg + 1'b1;
  end

  assign osc_tick = (osc_cnt_reg >= osc_div_reg);
  assign pif.start = blank_fall && probe_en && running;
  assign pif.stop = blank_rise;
  assign pif.tick = osc_tick;
  assign pif.time_sel = ctrl_reg[`CTRL_TIM_HI:`CTRL_TIM_LO];

  probe_timer #(.CNT_W(8)) u_timer
  (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .pif(pif)
  );

  // ----------------------------------------------------------------
  // Detection and capture
  // ----------------------------------------------------------------
  logic [4:0] settle_reg; // Cycles since outputs went on
  logic settled; // Comparators trustworthy
  logic [15:0] open_det, short_det, leak_det; // Masked detector bits
  logic [15:0] chosen; // Detector picked by select
  logic [15:0] probe_mask; // Off outputs seen during probe
  logic leak_en; // Leakage source and detector on
  logic capture; // Store into holder this cycle

  // Count settle time from the blank falling edge
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      settle_reg <= '0;
    else if (blank_s)
      settle_reg <= '0;
    else if (settle_reg != 5'(SETTLE_CYC))
      settle_reg <= settle_reg + 1'b1;
  end

  assign settled = (settle_reg == 5'(SETTLE_CYC)) && running;
  assign probe_mask = {16{probe_en}};
  assign open_det = open_s & (onoff_reg | probe_mask)
                    & {16{settled}};
  assign short_det = short_s & (onoff_reg | probe_mask)
                     & {16{settled}};
  assign leak_en = (sel == led_diag_pkg::SEL_LEAK) && !blank_s
                   && !probe_en && running;
  // Gate by last cycle's source: at the blank rise the source is just off
  assign leak_det = leak_s & ~onoff_reg & {16{leak_source}};

  // Pick the group named by the select
  always_comb
  begin
    unique case (sel)
      led_diag_pkg::SEL_OPEN: chosen = open_det;
      led_diag_pkg::SEL_SHORT: chosen = short_det;
      led_diag_pkg::SEL_LEAK: chosen = leak_det;
      led_diag_pkg::SEL_NONE: chosen = holder_reg;
    endcase
  end

  // Probe mode captures at window end, otherwise at blank rise
  assign capture = probe_en ?
    (pif.active && (blank_rise || pif.done)) :
    blank_rise;

  // Holder starts clean so nothing reads as a fault
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      holder_reg <= '0;
    else if (capture && sel != led_diag_pkg::SEL_NONE)
      holder_reg <= chosen;
  end

  // ----------------------------------------------------------------
  // Outputs to the output stage
  // ----------------------------------------------------------------
  // Registered so the pins never glitch
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_drive <= '0;
      probe_sink <= 1'b0;
      leak_source <= 1'b0;
      serial_out <= 1'b0;
    end
    else
    begin
      out_drive <= (running && !blank_s && !pif.active) ? onoff_reg : '0;
      probe_sink <= pif.active;
      leak_source <= leak_en;
      serial_out <= shift_reg[`SR_MSB];
    end
  end

  assign probe_current_select = ctrl_reg[`CTRL_CUR_HI:`CTRL_CUR_LO];
  assign short_threshold_select = ctrl_reg[`CTRL_THR_HI:`CTRL_THR_LO];
  assign brightness = ctrl_reg[`CTRL_BRIGHT_HI:0];
  assign sleep_mode = (pwr_reg == led_diag_pkg::PWR_SLEEP);

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  logic req; // New request this cycle

  assign req = cyc_i && stb_i && !ack_o;

  // One wait cycle; unmapped reads return zero
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ack_o <= 1'b0;
      dat_o <= '0;
      osc_div_reg <= OSC_DIV_INIT;
    end
    else
    begin
      ack_o <= req;
      if (req && we_i && sel_i[0] && adr_i == `ADR_OSC_DIV
          && dat_i[7:0] != 8'h00)
        osc_div_reg <= dat_i[7:0];
      if (req && !we_i)
      begin
        unique case (adr_i)
          `ADR_STATUS:
            dat_o <= {12'h000, fresh_reg, pif.active,
                      pwr_reg == led_diag_pkg::PWR_WAKE, sleep_mode,
                      holder_reg};
          `ADR_LATCH: dat_o <= {ctrl_reg, onoff_reg};
          `ADR_OSC_DIV: dat_o <= {24'h000000, osc_div_reg};
          default: dat_o <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  a_no_status_load: assert property (
    latch_go && onoff_wr && sel == led_diag_pkg::SEL_NONE
    |=> shift_reg[15:0] == $past(shift_reg[15:0]))
    else $error("status loaded with select 00");

  a_shutdown_ones: assert property (
    latch_go && onoff_wr && sel == led_diag_pkg::SEL_OPEN && tsd_s
    |=> shift_reg[15:0] == 16'hffff)
    else $error("shutdown did not force all ones");

  a_sleep_blocked: assert property (
    running && !ctrl_reg[15] && !(latch_go && !onoff_wr)
    |=> pwr_reg != led_diag_pkg::PWR_SLEEP)
    else $error("entered sleep while disabled");

  a_wake_edge: assert property (
    pwr_reg == led_diag_pkg::PWR_SLEEP && sclk_rise
    |=> pwr_reg == led_diag_pkg::PWR_WAKE ##1 !sleep_mode [*8])
    else $error("shift clock did not wake");

  a_leak_gate: assert property (
    leak_source |-> $past(sel) == led_diag_pkg::SEL_LEAK
    && !$past(blank_s) && !$past(probe_en))
    else $error("leak source on out of mode");

  a_probe_start: assert property (
    pif.start |=> pif.active ##1 probe_sink)
    else $error("probe did not start on blank fall");

  a_probe_off: assert property (
    !probe_en && !pif.active |=> !pif.active)
    else $error("probe ran while disabled");

  a_stale_latch: assert property (
    lat_rise && !fresh_reg
    |=> $stable(onoff_reg) && $stable(ctrl_reg) && $stable(shift_reg))
    else $error("latch acted without fresh data");

  a_settle_mask: assert property (
    blank_fall |-> (open_det == 16'h0000 && short_det == 16'h0000) [*8])
    else $error("detector valid before settle time");

endmodule

// ### verilog/led_diag_defs.svh
// Constants for the LED driver diagnostic and status capture block.
// Assumes inclusion by bare name from files under verilog/.
`ifndef LED_DIAG_DEFS_SVH
`define LED_DIAG_DEFS_SVH

// ----------------------------------------------------------------
// Shift register and control latch layout
// ----------------------------------------------------------------
`define SR_MSB 16
`define CTRL_RESET 16'he67f
`define CTRL_BRIGHT_HI 6
`define CTRL_SEL_HI 8
`define CTRL_SEL_LO 7
`define CTRL_THR_HI 10
`define CTRL_THR_LO 9
`define CTRL_CUR_HI 12
`define CTRL_CUR_LO 11
`define CTRL_TIM_HI 14
`define CTRL_TIM_LO 13
`define CTRL_SLEEP_BIT 15

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_MHZ 50
`define SETTLE_NS 500
`define WAKE_US 20
`define PROBE_MIN_OSC 17

// ----------------------------------------------------------------
// Wishbone register map
// ----------------------------------------------------------------
`define ADR_STATUS 8'h00
`define ADR_LATCH 8'h04
`define ADR_OSC_DIV 8'h08
`define OSC_DIV_RESET 8'h01

`endif

// ### verilog/led_diag_pkg.sv
// Types of the diagnostic block; its probe timer does not use them.
// Assumes nothing beyond a SystemVerilog compiler.
package led_diag_pkg;

  // ----------------------------------------------------------------
  // Detector group selection
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    SEL_NONE = 2'h0,
    SEL_OPEN = 2'h1,
    SEL_SHORT = 2'h2,
    SEL_LEAK = 2'h3
  } status_sel_type;

  // ----------------------------------------------------------------
  // Power states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    PWR_RUN = 3'h1,
    PWR_SLEEP = 3'h2,
    PWR_WAKE = 3'h4
  } power_state_type;

endpackage

// ### verilog/probe_if.sv
// Carrier between the diagnostic core and its probe timer.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface probe_if;
  logic start; // Begin probe window
  logic stop; // Blank rose, end window early
  logic tick; // Internal oscillator enable
  logic [1:0] time_sel; // Probe time code
  logic active; // Probe sinking in progress
  logic done; // Window expired, one cycle

  modport ctrl
  (
    output start,
    output stop,
    output tick,
    output time_sel,
    input active,
    input done
  );
  modport timer
  (
    input start,
    input stop,
    input tick,
    input time_sel,
    output active,
    output done
  );
endinterface

// ### verilog/probe_timer.sv
// Probe window timer counted in internal oscillator ticks.
// Assumes start, stop and tick are synchronous to clk_sys.
`timescale 1ns/1ps
`include "led_diag_defs.svh"
module probe_timer
#(
  parameter int CNT_W = 8
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Control side
  probe_if.timer pif
);

  // Longest window is 129 ticks
  initial
  begin
    if (CNT_W < 8)
      $error("probe_timer: CNT_W too small");
  end

  logic [CNT_W-1:0] cnt_reg; // Ticks elapsed
  logic active_reg; // Window open
  logic [CNT_W-1:0] limit; // Window length in ticks
  logic expire; // Last tick of the window

  // Lengths 17, 33, 65, 129
  assign limit = CNT_W'(((`PROBE_MIN_OSC - 1) << pif.time_sel) + 1);
  assign expire = active_reg && pif.tick && (cnt_reg == limit - 1'b1);

  // Window state; stop wins so a late expiry is never seen
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      active_reg <= 1'b0;
      cnt_reg <= '0;
    end
    else if (pif.start)
    begin
      active_reg <= 1'b1;
      cnt_reg <= '0;
    end
    else if (pif.stop || expire)
      active_reg <= 1'b0;
    else if (active_reg && pif.tick)
      cnt_reg <= cnt_reg + 1'b1;
  end

  assign pif.active = active_reg;
  assign pif.done = expire && !pif.stop;

endmodule
